// ### rji_buf.sv
// Purpose: Two-entry buffer between the word capture and the RAM write stage.
// Assumes: Push and pop are single-cycle handshakes on CLK.
// Notes:   in_ready falls only when both entries hold a word.
module rji_buf
   import rji_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = 2
)(
   input  wire logic         CLK,
   input  wire logic         RST,
   input  wire logic         IN_VALID,
   output logic              IN_READY,
   input  wire logic [W-1:0] IN_DATA,
   output logic              OUT_VALID,
   input  wire logic         OUT_READY,
   output logic [W-1:0]      OUT_DATA
);
   logic [W-1:0] mem_ff [DEPTH];
   logic [W-1:0] nxt_mem [DEPTH];
   logic         wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [1:0]   cnt_ff, nxt_cnt;
   logic         push, pop;

   assign IN_READY  = (cnt_ff != 2'(DEPTH));
   assign OUT_VALID = (cnt_ff != 2'h0);
   assign OUT_DATA  = mem_ff[rp_ff];
   assign push      = IN_VALID && IN_READY;
   assign pop       = OUT_VALID && OUT_READY;

   always_comb
   begin
      nxt_mem = mem_ff;
      nxt_wp  = wp_ff;
      nxt_rp  = rp_ff;
      nxt_cnt = cnt_ff;
      if (push)
      begin
         nxt_mem[wp_ff] = IN_DATA;
         nxt_wp         = ~wp_ff;
      end
      if (pop)
      begin
         nxt_rp = ~rp_ff;
      end
      nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge CLK)
   begin
      mem_ff <= nxt_mem;
      if (RST)
      begin
         wp_ff  <= 1'b0;
         rp_ff  <= 1'b0;
         cnt_ff <= 2'h0;
      end
      else
      begin
         wp_ff  <= nxt_wp;
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end

endmodule // rji_buf

// ### rji_init.sv
// Purpose: Loads serial JTAG data words into RAM blocks with counted addresses.
// Assumes: All link inputs are asynchronous to CLK and change far slower than it.
// Notes:   RAM_WCLK rises (or falls, with WCLK_FALL) once per written word.
module rji_init
   import rji_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire rji_link_t  LINK_IN,
   input  wire logic       WCLK_FALL,
   input  wire logic       SHARE_ALL,
   input  wire logic       RAM_READY,
   output rji_ram_t        RAM_OUT,
   output logic            RAM_WCLK,
   output logic            LINK_READY,
   output logic            OVERRUN
);

   // -----------------------------------------------------------------------
   // Functions
   // -----------------------------------------------------------------------
   function automatic logic is_blk_op(input logic [IR_W-1:0] op);
      return (op >= OP_BLK0) && (op < 8'(OP_BLK0 + NBLK));
   endfunction

   function automatic logic is_write_op(input logic [IR_W-1:0] op);
      return (op == OP_START) || is_blk_op(op);
   endfunction

   // -----------------------------------------------------------------------
   // Link synchroniser
   // -----------------------------------------------------------------------
   rji_link_t link_meta_ff, link_ff;
   logic      drck_d_ff, upd_d_ff;
   logic      drck_rise, upd_rise;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         link_meta_ff <= '0;
         link_ff      <= '0;
         drck_d_ff    <= 1'b0;
         upd_d_ff     <= 1'b0;
      end
      else
      begin
         link_meta_ff <= LINK_IN;
         link_ff      <= link_meta_ff;
         drck_d_ff    <= link_ff.drck;
         upd_d_ff     <= link_ff.update;
      end
   end

   assign drck_rise = link_ff.drck && !drck_d_ff;
   assign upd_rise  = link_ff.update && !upd_d_ff;

   // -----------------------------------------------------------------------
   // Serial shift register and word capture
   // -----------------------------------------------------------------------
   logic [DATA_W-1:0] sr_ff, nxt_sr;
   logic              ovr_ff, nxt_ovr;
   rji_entry_t        push_ent;
   logic              push_valid, buf_in_ready;

   always_comb
   begin
      nxt_sr  = sr_ff;
      nxt_ovr = ovr_ff;
      if (drck_rise && link_ff.shift)
      begin
         nxt_sr = {link_ff.tdi, sr_ff[DATA_W-1:1]};
      end
      if (push_valid && !buf_in_ready)
      begin
         nxt_ovr = 1'b1;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sr_ff  <= '0;
         ovr_ff <= 1'b0;
      end
      else
      begin
         sr_ff  <= nxt_sr;
         ovr_ff <= nxt_ovr;
      end
   end

   // A word is taken only under an opcode that means something to this block.
   assign push_valid = upd_rise && (is_write_op(link_ff.instr) || link_ff.instr == OP_ADDR);
   always_comb
   begin
      push_ent.is_addr = (link_ff.instr == OP_ADDR);
      push_ent.direct  = is_blk_op(link_ff.instr);
      push_ent.blk     = 2'(link_ff.instr - OP_BLK0);
      push_ent.word    = sr_ff;
   end

   rji_entry_t buf_ent;
   logic       buf_valid, pop;

   rji_buf #(
      .W     ($bits(rji_entry_t)),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .CLK       (CLK),
      .RST       (RST),
      .IN_VALID  (push_valid),
      .IN_READY  (buf_in_ready),
      .IN_DATA   (push_ent),
      .OUT_VALID (buf_valid),
      .OUT_READY (pop),
      .OUT_DATA  (buf_ent)
   );

   // -----------------------------------------------------------------------
   // Write stage: pipeline register, address counter, block select
   // -----------------------------------------------------------------------
   rji_wstate_t       state_ff, nxt_state;
   logic [2:0]        cnt_ff, nxt_cnt;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [DATA_W-1:0] data_ff, nxt_data;
   logic [NBLK-1:0]   ring_ff, nxt_ring;
   logic              started_ff, nxt_started;
   logic              wclk_ff, nxt_wclk;
   logic              direct_ff, nxt_direct;
   logic [1:0]        blk_ff, nxt_blk;
   logic              drain_ok, write_act;

   assign write_act = is_write_op(link_ff.instr);
   assign drain_ok  = write_act || (link_ff.instr == OP_ADDR);

   always_comb
   begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_addr    = addr_ff;
      nxt_data    = data_ff;
      nxt_ring    = ring_ff;
      nxt_started = started_ff;
      nxt_wclk    = wclk_ff;
      nxt_direct  = direct_ff;
      nxt_blk     = blk_ff;
      pop         = 1'b0;
      unique case (state_ff)
         WS_IDLE:
         begin
            if (buf_valid && RAM_READY && drain_ok)
            begin
               pop = 1'b1;
               if (buf_ent.is_addr)
               begin
                  nxt_addr = ADDR_W'(buf_ent.word - 1'b1);
               end
               else
               begin
                  nxt_addr = ADDR_W'(addr_ff + 1'b1);
                  if (started_ff && addr_ff == ADDR_LAST && !buf_ent.direct)
                  begin
                     nxt_ring = {ring_ff[NBLK-2:0], ring_ff[NBLK-1]};
                  end
                  nxt_started = 1'b1;
                  nxt_data    = buf_ent.word;
                  nxt_direct  = buf_ent.direct;
                  nxt_blk     = buf_ent.blk;
                  nxt_wclk    = 1'b0;
                  nxt_cnt     = SETUP_LOAD;
                  nxt_state   = WS_SETUP;
               end
            end
         end
         WS_SETUP:
         begin
            if (cnt_ff == 3'h0)
            begin
               nxt_wclk  = 1'b1;
               nxt_state = WS_IDLE;
            end
            else
            begin
               nxt_cnt = 3'(cnt_ff - 1'b1);
            end
         end
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_ff   <= WS_IDLE;
         cnt_ff     <= 3'h0;
         addr_ff    <= ADDR_PRESET;
         data_ff    <= '0;
         ring_ff    <= RING_RESET;
         started_ff <= 1'b0;
         wclk_ff    <= 1'b1;
         direct_ff  <= 1'b0;
         blk_ff     <= 2'h0;
      end
      else
      begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         addr_ff    <= nxt_addr;
         data_ff    <= nxt_data;
         ring_ff    <= nxt_ring;
         started_ff <= nxt_started;
         wclk_ff    <= nxt_wclk;
         direct_ff  <= nxt_direct;
         blk_ff     <= nxt_blk;
      end
   end

   // -----------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------
   logic [NBLK-1:0] sel;

   always_comb
   begin
      if (SHARE_ALL)
      begin
         sel = '1;
      end
      else if (direct_ff)
      begin
         sel = NBLK'(1) << blk_ff;
      end
      else
      begin
         sel = ring_ff;
      end
   end

   assign RAM_OUT = '{data: data_ff,
                      addr: addr_ff,
                      wen:  (write_act && started_ff) ? sel : 4'h0};
   assign RAM_WCLK     = wclk_ff ^ WCLK_FALL;
   assign LINK_READY   = buf_in_ready;
   assign OVERRUN      = ovr_ff;

   // -----------------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   a_wen_no_op: assert property (!write_act |-> RAM_OUT.wen == '0)
      else $error("write enable active without initialisation opcode");
   a_shift_hold: assert property (drck_rise && !link_ff.shift |=> $stable(sr_ff))
      else $error("shift register moved without shift indication");
   a_shift_bit: assert property (drck_rise && link_ff.shift |=>
      sr_ff == {$past(link_ff.tdi), $past(sr_ff[DATA_W-1:1])})
      else $error("serial bit not shifted in");
   a_upd_push: assert property (upd_rise && link_ff.instr == OP_START && buf_in_ready
      |=> buf_valid)
      else $error("update strobe did not capture the word");
   a_addr_step: assert property (pop && !buf_ent.is_addr |=>
      addr_ff == ADDR_W'($past(addr_ff) + 1'b1) && data_ff == $past(buf_ent.word))
      else $error("address or data did not advance with the word");
   a_addr_first: assert property (pop && !buf_ent.is_addr && !started_ff
      && addr_ff == ADDR_PRESET |=> addr_ff == '0)
      else $error("first word not written at address zero");
   a_wclk_setup: assert property ($fell(wclk_ff) |-> (!wclk_ff)[*4] ##1 wclk_ff)
      else $error("write clock setup time wrong");
   a_data_stable: assert property (!wclk_ff && !$past(wclk_ff) |-> $stable(RAM_OUT))
      else $error("data or address changed before write clock edge");
   a_ring_hot: assert property ($onehot(ring_ff))
      else $error("block ring counter not one-hot");
   a_addr_hold: assert property (!drain_ok |=> $stable(addr_ff))
      else $error("address moved without an initialisation opcode");
   a_share_all: assert property (SHARE_ALL && write_act && started_ff |->
      RAM_OUT.wen == '1)
      else $error("shared enable did not select every block");

   c_word_write: cover property (pop && !buf_ent.is_addr ##[1:8] $rose(wclk_ff));
   c_ring_step: cover property (started_ff && $changed(ring_ff));
   c_buf_full: cover property (!buf_in_ready);
   c_addr_load: cover property (pop && buf_ent.is_addr);

endmodule // rji_init

// ### rji_pkg.sv
// Purpose: Shared constants and types for the JTAG RAM initialisation interface.
// Assumes: A 250 MHz system clock samples every signal of the user TAP macro.
// Notes:   Opcodes and sizes are plain defaults that a design adapts to its memories.
package rji_pkg;

   // -----------------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------------
   localparam int DATA_W = 4;
   localparam int ADDR_W = 2;
   localparam int NBLK   = 4;
   localparam int IR_W   = 8;
   localparam int BUF_DEPTH = 2;

   // -----------------------------------------------------------------------
   // Instruction opcodes
   // -----------------------------------------------------------------------
   localparam logic [IR_W-1:0] OP_START = 8'h22;
   localparam logic [IR_W-1:0] OP_ADDR  = 8'h24;
   localparam logic [IR_W-1:0] OP_BLK0  = 8'h30;

   // -----------------------------------------------------------------------
   // Reset values and timing
   // -----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_PRESET = 2'h3;
   localparam logic [ADDR_W-1:0] ADDR_LAST   = 2'h3;
   localparam logic [NBLK-1:0]   RING_RESET  = 4'h1;
   localparam int CLK_PERIOD_NS  = 4;
   localparam int WCLK_SETUP_NS  = 16;
   localparam int WCLK_SETUP_CYC = (WCLK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] SETUP_LOAD = 3'(WCLK_SETUP_CYC - 1);

   // -----------------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------------
   typedef struct packed {
      logic [IR_W-1:0] instr;
      logic            shift;
      logic            update;
      logic            tdi;
      logic            drck;
   } rji_link_t;

   typedef struct packed {
      logic              is_addr;
      logic              direct;
      logic [1:0]        blk;
      logic [DATA_W-1:0] word;
   } rji_entry_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [ADDR_W-1:0] addr;
      logic [NBLK-1:0]   wen;
   } rji_ram_t;

   typedef enum logic {
      WS_IDLE  = 1'b0,
      WS_SETUP = 1'b1
   } rji_wstate_t;

endpackage

// ### rji_tap_model.sv
// Purpose: Behavioural user TAP macro plus board JTAG driver facing rji_init.
// Assumes: Link lines change on falling CLK edges; drck has a 64 ns period.
// Notes:   drck pulses once with shift low after each word; tdi shows the inverse bit when idle.
module rji_tap_model
   import rji_pkg::*;
(
   input  wire logic clk,
   output rji_link_t link
);
   timeunit 1ns;
   timeprecision 1ps;

   rji_link_t lk = '0;
   assign link = lk;

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // -----------------------------------------------------------------------
   // Driver sequences
   // -----------------------------------------------------------------------
   task automatic load(input logic [IR_W-1:0] op);
      lk.instr = op;
      tick(8);
   endtask

   task automatic word(input logic [DATA_W-1:0] w);
      lk.shift = 1'b1;
      for (int i = 0; i < DATA_W; i++)
      begin
         lk.tdi = w[i];
         tick(8);
         lk.drck = 1'b1;
         tick(8);
         lk.drck = 1'b0;
      end
      lk.shift = 1'b0;
      lk.tdi = ~lk.tdi;
      tick(8);
      // A pulse with shift low must leave the loaded word untouched.
      lk.drck = 1'b1;
      tick(8);
      lk.drck = 1'b0;
      tick(8);
      lk.update = 1'b1;
      tick(8);
      lk.update = 1'b0;
      tick(8);
   endtask
endmodule // rji_tap_model

// ### tb.sv
// Purpose: Self-checking bench for rji_init driven through the TAP model.
// Assumes: Words are written on the rising edge of RAM_WCLK xor WCLK_FALL.
// Notes:   Expected writes are queued by the driver and popped by the monitor.
module tb
   import rji_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              CLK;
   logic              RST;
   logic              WCLK_FALL;
   logic              SHARE_ALL;
   logic              RAM_READY;
   rji_link_t         link;
   rji_ram_t          RAM_OUT;
   logic              RAM_WCLK;
   logic              LINK_READY;
   logic              OVERRUN;
   int                err_count = 0;
   int                n_checks = 0;
   int                low_cnt = 0;
   rji_ram_t          exp_q[$];
   rji_ram_t          exp_w;
   logic [ADDR_W-1:0] e_addr;
   logic [NBLK-1:0]   e_ring;
   logic              started;
   logic              prev_hi;

   rji_init dut_u (.CLK(CLK), .RST(RST), .LINK_IN(link), .WCLK_FALL(WCLK_FALL),
      .SHARE_ALL(SHARE_ALL), .RAM_READY(RAM_READY), .RAM_OUT(RAM_OUT),
      .RAM_WCLK(RAM_WCLK), .LINK_READY(LINK_READY), .OVERRUN(OVERRUN));
   rji_tap_model tap_u (.clk(CLK), .link(link));

   initial
   begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   // -----------------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic do_reset(input logic fall);
      @(negedge CLK);
      RST = 1'b1;
      WCLK_FALL = fall;
      repeat (20) @(negedge CLK);
      chk(RAM_OUT, {4'h0, ADDR_PRESET, 4'h0}, "reset outputs");
      chk(RAM_WCLK, {~fall}, "reset write clock");
      chk({LINK_READY, OVERRUN}, 2'b10, "reset flags");
      RST = 1'b0;
      e_addr = ADDR_PRESET;
      e_ring = RING_RESET;
      started = 1'b0;
      repeat (3) @(negedge CLK);
   endtask

   // Loads the opcode, notes the expected write unless the word is to be lost.
   task automatic put(input logic [IR_W-1:0] op, input logic [DATA_W-1:0] w, input bit keep);
      logic [NBLK-1:0] sel;
      tap_u.load(op);
      if (op == OP_ADDR)
         e_addr = w[ADDR_W-1:0] - 1'b1;
      else if (keep && (op == OP_START || (op >= OP_BLK0 && op < OP_BLK0 + NBLK)))
      begin
         if (op == OP_START && started && e_addr == ADDR_LAST)
            e_ring = {e_ring[NBLK-2:0], e_ring[NBLK-1]};
         sel = (op == OP_START) ? e_ring : NBLK'(1) << (op - OP_BLK0);
         e_addr = e_addr + 1'b1;
         started = 1'b1;
         exp_q.push_back({w, e_addr, SHARE_ALL ? 4'hf : sel});
      end
      tap_u.word(w);
   endtask

   // -----------------------------------------------------------------------
   // Write monitor
   // -----------------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (RST)
      begin
         prev_hi = 1'b1;
         low_cnt = 0;
      end
      else
      begin
         if ((RAM_WCLK ^ WCLK_FALL) === 1'b0)
            low_cnt++;
         else if (!prev_hi)
         begin
            if (exp_q.size() == 0)
               chk(1'b1, 1'b0, "unexpected write");
            else
            begin
               exp_w = exp_q.pop_front();
               chk(RAM_OUT, exp_w, "write word");
               chk(low_cnt, WCLK_SETUP_CYC, "setup time");
            end
            low_cnt = 0;
         end
         prev_hi = ((RAM_WCLK ^ WCLK_FALL) === 1'b1);
      end
   end

   initial
   begin
      repeat (30000) @(posedge CLK);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end

   // -----------------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------------
   initial
   begin
      RST = 1'b1;
      WCLK_FALL = 1'b0;
      SHARE_ALL = 1'b0;
      RAM_READY = 1'b1;
      void'($urandom(2160));
      do_reset(1'b0);
      repeat (6) put(OP_START, $urandom, 1'b1);
      put(8'h55, $urandom, 1'b1);
      chk(RAM_OUT.wen, 4'h0, "write enable idle");
      put(OP_START, $urandom, 1'b1);
      for (int k = 0; k < NBLK; k++)
         put(OP_BLK0 + IR_W'(k), $urandom, 1'b1);
      repeat (2) put(OP_START, $urandom, 1'b1);
      put(OP_ADDR, 4'h2, 1'b1);
      repeat (3) put(OP_START, $urandom, 1'b1);
      SHARE_ALL = 1'b1;
      repeat (2) put(OP_START, $urandom, 1'b1);
      SHARE_ALL = 1'b0;
      RAM_READY = 1'b0;
      repeat (2) put(OP_START, $urandom, 1'b1);
      chk(LINK_READY, 1'b0, "buffer full");
      put(OP_START, $urandom, 1'b0);
      chk(OVERRUN, 1'b1, "lost word");
      RAM_READY = 1'b1;
      repeat (40) @(negedge CLK);
      chk(LINK_READY, 1'b1, "buffer drained");
      do_reset(1'b1);
      repeat (2) put(OP_START, $urandom, 1'b1);
      repeat (20) @(negedge CLK);
      chk(exp_q.size(), 0, "pending writes");
      wrap_up();
   end
endmodule // tb
